/* File: shared/ehci_cap_consts.svh */
`ifndef EHCI_CAP_CONSTS_SVH
`define EHCI_CAP_CONSTS_SVH

// Register byte offsets
`define CAP_PARAM_OFS 8'h08
`define PORT_ROUTE_OFS 8'h0C
`define HOST_CMD_OFS 8'h10

// Capability parameters fields
`define CAP_EXT_PTR_MSB 15
`define CAP_EXT_PTR_LSB 8
`define CAP_IST_MSB 7
`define CAP_IST_LSB 4
`define CAP_IST_FRAME_BIT 7
`define CAP_PARK_BIT 2
`define CAP_PFL_BIT 1
`define EXT_PTR_VALUE 8'h00
`define EXT_PTR_MIN 8'h40

// Command register fields and reset values
`define CMD_ITC_MSB 23
`define CMD_ITC_LSB 16
`define CMD_PARK_EN_BIT 11
`define CMD_PARK_CNT_MSB 9
`define CMD_PARK_CNT_LSB 8
`define CMD_FLS_MSB 3
`define CMD_FLS_LSB 2
`define CMD_RST_NOPARK 32'h00080000
`define CMD_RST_PARK 32'h00080B00

// Port route array
`define ROUTE_ELEM_W 4
`define ROUTE_ELEMS 15
`define ROUTE_NIBBLES 8
`define N_PORTS 1

// Micro-frame timing
`define UFRAME_NS 125000
`define CLK_PERIOD_NS 40
`define UFRAME_CYCLES (`UFRAME_NS / `CLK_PERIOD_NS)
`define UF_CNT_SAT 8'hFF

`endif

/* File: shared/ehci_cap_pkg.sv */
`default_nettype none
package ehci_cap_pkg;
  typedef logic [7:0] thresh_t;
  typedef logic [1:0] fl_size_t;
  typedef logic [3:0] route_elem_t;
  typedef enum {SEL_NONE, SEL_CAP, SEL_ROUTE, SEL_CMD} reg_sel_t;
endpackage : ehci_cap_pkg
`default_nettype wire

/* File: logic/uframe_tick.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ehci_cap_consts.svh"
module uframe_tick
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Micro-frame boundary pulse
  output var logic tick
);
  localparam logic [11:0] LAST = 12'(`UFRAME_CYCLES - 1);
  logic [11:0] count;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 12'h000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (count == LAST);
      count <= (count == LAST) ? 12'h000 : count + 12'h001;
    end
  end
endmodule : uframe_tick
`default_nettype wire

/* File: logic/irq_throttle.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ehci_cap_consts.svh"
module irq_throttle
  import ehci_cap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Timing and threshold
  input wire logic uframe_tick,
  input wire ehci_cap_pkg::thresh_t thresh,
  // Events in, interrupt out
  input wire logic event_in,
  output var logic irq
);
  logic pending;
  logic [7:0] uf_count;
  logic [7:0] next_uf;
  logic fire;

  // Saturates so an idle controller answers the first event at the next micro-frame tick
  assign next_uf = (uf_count == `UF_CNT_SAT) ? uf_count : uf_count + 8'h01;
  assign fire = uframe_tick && pending && (next_uf >= thresh);

  // A new event in the firing cycle stays pending
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pending <= 1'b0;
    else
      pending <= event_in || (pending && !fire);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      uf_count <= `UF_CNT_SAT;
    else if (fire)
      uf_count <= 8'h00;
    else if (uframe_tick)
      uf_count <= next_uf;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= fire;
  end

  // Separate tick count since the last interrupt, so the check does not reuse the firing logic
  logic [7:0] gap_ticks;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_ticks <= `UF_CNT_SAT;
    else if (irq)
      gap_ticks <= 8'h00;
    else if (uframe_tick && (gap_ticks != `UF_CNT_SAT))
      gap_ticks <= gap_ticks + 8'h01;
  end

  property p_irq_spacing;
    @(posedge clk) disable iff (!rst_n)
    irq |-> (gap_ticks >= $past(thresh));
  endproperty
  a_irq_spacing: assert property (p_irq_spacing) else $error("interrupt before threshold elapsed");

  property p_irq_restart;
    @(posedge clk) disable iff (!rst_n)
    irq |-> (uf_count == 8'h00) || $past(uframe_tick) == 1'b0;
  endproperty
  a_irq_restart: assert property (p_irq_restart) else $error("interval count not restarted");
endmodule : irq_throttle
`default_nettype wire

/* File: logic/ehci_cap_cmd_regs.sv */
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ehci_cap_consts.svh"
module ehci_cap_cmd_regs
  import ehci_cap_pkg::*;
#(
  parameter logic PARK_CAP = 1'b1,
  parameter logic PROG_FRAME_LIST = 1'b1,
  parameter logic [3:0] ISO_THRESHOLD = 4'h2,
  parameter ehci_cap_pkg::route_elem_t ROUTE_PORT0 = 4'h0
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output var logic [31:0] PRDATA,
  output var logic PREADY,
  output var logic PSLVERR,
  // Controller event to be throttled
  input wire logic INT_EVENT,
  output var logic INT_OUT,
  // Command state towards the schedule engine
  output var ehci_cap_pkg::thresh_t INT_THRESHOLD,
  output var logic PARK_MODE_ON,
  output var logic [1:0] PARK_COUNT,
  output var ehci_cap_pkg::fl_size_t FRAME_LIST_SIZE
);
  localparam logic [31:0] CMD_RESET = PARK_CAP ? `CMD_RST_PARK : `CMD_RST_NOPARK;

  logic setup;
  logic wr_cmd;
  logic uframe;
  reg_sel_t rd_sel;
  reg_sel_t wr_sel;
  logic [31:0] cap_word;
  logic [31:0] route_word;
  logic [31:0] cmd_word;
  logic [31:0] next_rdata;

  function automatic reg_sel_t decode(input logic [7:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == `CAP_PARAM_OFS)
      sel = SEL_CAP;
    else if (addr == `PORT_ROUTE_OFS)
      sel = SEL_ROUTE;
    else if (addr == `HOST_CMD_OFS)
      sel = SEL_CMD;
    return sel;
  endfunction : decode

  assign rd_sel = decode(PADDR);
  assign wr_sel = decode(PADDR);
  assign setup = PSEL && !PENABLE;
  assign wr_cmd = PSEL && PENABLE && PREADY && PWRITE && (wr_sel == SEL_CMD);

  // Capability word: constants only, so software sees it at once after reset
  always_comb
  begin
    cap_word = 32'h00000000;
    cap_word[`CAP_EXT_PTR_MSB:`CAP_EXT_PTR_LSB] = `EXT_PTR_VALUE;
    cap_word[`CAP_IST_MSB:`CAP_IST_LSB] = ISO_THRESHOLD;
    cap_word[`CAP_PARK_BIT] = PARK_CAP;
    cap_word[`CAP_PFL_BIT] = PROG_FRAME_LIST;
  end

  // Route nibbles beyond the implemented ports read zero
  generate
    for (genvar i = 0; i < `ROUTE_NIBBLES; i++)
    begin : g_route
      if (i < `N_PORTS)
      begin : g_used
        assign route_word[i*`ROUTE_ELEM_W +: `ROUTE_ELEM_W] = ROUTE_PORT0;
      end
      else
      begin : g_unused
        assign route_word[i*`ROUTE_ELEM_W +: `ROUTE_ELEM_W] = 4'h0;
      end
    end
  endgenerate

  always_comb
  begin
    cmd_word = 32'h00000000;
    cmd_word[`CMD_ITC_MSB:`CMD_ITC_LSB] = INT_THRESHOLD;
    cmd_word[`CMD_PARK_EN_BIT] = PARK_MODE_ON;
    cmd_word[`CMD_PARK_CNT_MSB:`CMD_PARK_CNT_LSB] = PARK_COUNT;
    cmd_word[`CMD_FLS_MSB:`CMD_FLS_LSB] = FRAME_LIST_SIZE;
  end

  always_comb
  begin
    unique case (rd_sel)
      SEL_CAP: next_rdata = cap_word;
      SEL_ROUTE: next_rdata = route_word;
      SEL_CMD: next_rdata = cmd_word;
      SEL_NONE: next_rdata = 32'h00000000;
    endcase
  end

  // Read data and ready are prepared in the setup cycle so both leave flops
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup && (rd_sel == SEL_NONE);
      if (setup)
        PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
    end
  end

  // Threshold is taken as written; unlisted values are software's problem
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      INT_THRESHOLD <= CMD_RESET[`CMD_ITC_MSB:`CMD_ITC_LSB];
    else if (wr_cmd)
      INT_THRESHOLD <= PWDATA[`CMD_ITC_MSB:`CMD_ITC_LSB];
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PARK_MODE_ON <= CMD_RESET[`CMD_PARK_EN_BIT];
      PARK_COUNT <= CMD_RESET[`CMD_PARK_CNT_MSB:`CMD_PARK_CNT_LSB];
    end
    else if (wr_cmd && PARK_CAP)
    begin
      PARK_MODE_ON <= PWDATA[`CMD_PARK_EN_BIT];
      PARK_COUNT <= PWDATA[`CMD_PARK_CNT_MSB:`CMD_PARK_CNT_LSB];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      FRAME_LIST_SIZE <= CMD_RESET[`CMD_FLS_MSB:`CMD_FLS_LSB];
    else if (wr_cmd && PROG_FRAME_LIST)
      FRAME_LIST_SIZE <= PWDATA[`CMD_FLS_MSB:`CMD_FLS_LSB];
  end

  uframe_tick u_tick
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .tick(uframe)
  );

  irq_throttle u_throttle
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .uframe_tick(uframe),
    .thresh(INT_THRESHOLD),
    .event_in(INT_EVENT),
    .irq(INT_OUT)
  );

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_read_setup(logic [7:0] ofs);
    PSEL && !PENABLE && !PWRITE && (PADDR == ofs);
  endsequence

  sequence s_cmd_write;
    PSEL && PENABLE && PREADY && PWRITE && (PADDR == `HOST_CMD_OFS);
  endsequence

  logic first_cycle;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      first_cycle <= 1'b1;
    else
      first_cycle <= 1'b0;
  end

  property p_ext_ptr_zero;
    s_read_setup(`CAP_PARAM_OFS) |=> PREADY && (PRDATA[15:8] == 8'h00);
  endproperty
  a_ext_ptr_zero: assert property (p_ext_ptr_zero) else $error("extended pointer not zero");

  property p_ext_ptr_legal;
    s_read_setup(`CAP_PARAM_OFS) |=> (PRDATA[15:8] == 8'h00) || (PRDATA[15:8] >= `EXT_PTR_MIN);
  endproperty
  a_ext_ptr_legal: assert property (p_ext_ptr_legal) else $error("extended pointer below 40h");

  property p_cap_fields;
    s_read_setup(`CAP_PARAM_OFS) |=> (PRDATA[7:4] == ISO_THRESHOLD) && (PRDATA[2] == PARK_CAP)
      && (PRDATA[1] == PROG_FRAME_LIST);
  endproperty
  a_cap_fields: assert property (p_cap_fields) else $error("capability fields wrong");

  property p_cap_reserved;
    s_read_setup(`CAP_PARAM_OFS) |=> (PRDATA[31:16] == 16'h0000) && !PRDATA[3] && !PRDATA[0];
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("capability reserved bits set");

  property p_route_layout;
    s_read_setup(`PORT_ROUTE_OFS) |=> (PRDATA[3:0] == ROUTE_PORT0) && (PRDATA[31:4] == 28'h0000000);
  endproperty
  a_route_layout: assert property (p_route_layout) else $error("route array layout wrong");

  property p_cmd_reset;
    first_cycle |-> (cmd_word == CMD_RESET);
  endproperty
  a_cmd_reset: assert property (p_cmd_reset) else $error("command reset value wrong");

  property p_itc_write;
    s_cmd_write |=> (INT_THRESHOLD == $past(PWDATA[23:16]));
  endproperty
  a_itc_write: assert property (p_itc_write) else $error("threshold write lost");

  property p_park_ro;
    !PARK_CAP |-> !PARK_MODE_ON && (PARK_COUNT == 2'b00);
  endproperty
  a_park_ro: assert property (p_park_ro) else $error("park bit set without capability");

  property p_park_follow;
    s_cmd_write ##[1:2] s_read_setup(`HOST_CMD_OFS) |=> PRDATA[11] == PARK_MODE_ON;
  endproperty
  a_park_follow: assert property (p_park_follow) else $error("park mode readback mismatch");

  property p_fls_ro;
    !PROG_FRAME_LIST |-> (FRAME_LIST_SIZE == 2'b00);
  endproperty
  a_fls_ro: assert property (p_fls_ro) else $error("frame list size writable");

  property p_fls_write;
    s_cmd_write |=> (FRAME_LIST_SIZE == (PROG_FRAME_LIST ? $past(PWDATA[3:2]) : 2'b00));
  endproperty
  a_fls_write: assert property (p_fls_write) else $error("frame list size write lost");

  property p_cmd_reserved;
    s_read_setup(`HOST_CMD_OFS) |=> (PRDATA[31:24] == 8'h00) && (PRDATA[15:12] == 4'h0) && !PRDATA[10];
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved) else $error("command reserved bits set");

  property p_route_ro;
    PSEL && PENABLE && PWRITE && (PADDR == `PORT_ROUTE_OFS) |=> $stable(route_word);
  endproperty
  a_route_ro: assert property (p_route_ro) else $error("route register changed by write");

  property p_park_write;
    s_cmd_write |=> (PARK_MODE_ON == (PARK_CAP && $past(PWDATA[11])));
  endproperty
  a_park_write: assert property (p_park_write) else $error("park enable write wrong");

  property p_itc_read;
    s_read_setup(`HOST_CMD_OFS) |=> (PRDATA[23:16] == INT_THRESHOLD);
  endproperty
  a_itc_read: assert property (p_itc_read) else $error("threshold readback wrong");
endmodule : ehci_cap_cmd_regs
`default_nettype wire

/* File: test/usb2_host_capability_command_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module usb2_host_capability_command_regs_tb;
  import ehci_cap_pkg::*;
  localparam logic [7:0] CAP_A = 8'h08;
  localparam logic [7:0] ROUTE_A = 8'h0C;
  localparam logic [7:0] CMD_A = 8'h10;
  localparam logic [7:0] HOLE_A = 8'h14;
  localparam int UF = 3125;
  // Threshold 2, no frame flag, park and frame list capable
  localparam logic [31:0] CAP_EXP = 32'h00000026;
  // Route nibble zero made nonzero so a lost parameter shows
  localparam logic [31:0] ROUTE_EXP = 32'h00000005;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic INT_EVENT = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic INT_OUT;
  thresh_t INT_THRESHOLD;
  logic PARK_MODE_ON;
  logic [1:0] PARK_COUNT;
  fl_size_t FRAME_LIST_SIZE;
  logic [31:0] bare_rdata;
  logic bare_park;
  logic [1:0] bare_cnt;
  fl_size_t bare_fls;
  int num_errors = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;
  int n;
  thresh_t thr [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};

  always #20 REF_CLK = ~REF_CLK;

  ehci_cap_cmd_regs #(.PARK_CAP(1'b1), .PROG_FRAME_LIST(1'b1), .ISO_THRESHOLD(4'h2), .ROUTE_PORT0(4'h5))
  i_ehci_cap_cmd_regs (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INT_EVENT(INT_EVENT), .INT_OUT(INT_OUT), .INT_THRESHOLD(INT_THRESHOLD),
    .PARK_MODE_ON(PARK_MODE_ON), .PARK_COUNT(PARK_COUNT), .FRAME_LIST_SIZE(FRAME_LIST_SIZE));

  // Second slave on the same bus without park or programmable list, so the read-only paths run
  ehci_cap_cmd_regs #(.PARK_CAP(1'b0), .PROG_FRAME_LIST(1'b0), .ISO_THRESHOLD(4'h2), .ROUTE_PORT0(4'h0))
  i_ehci_cap_cmd_regs_bare (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(bare_rdata), .PREADY(), .PSLVERR(),
    .INT_EVENT(INT_EVENT), .INT_OUT(), .INT_THRESHOLD(),
    .PARK_MODE_ON(bare_park), .PARK_COUNT(bare_cnt), .FRAME_LIST_SIZE(bare_fls));

  task results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high; data taken at that edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do
    begin
      @(posedge REF_CLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      num_errors++;
      $display("[ERR] %0t bus answer missing", $time);
      results();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // One event pulse, then the cycles until the throttled interrupt
  task irq_gap(input int lo, input int hi, input string what);
    @(posedge REF_CLK);
    INT_EVENT <= 1'b1;
    @(posedge REF_CLK);
    INT_EVENT <= 1'b0;
    n = 1;
    while (INT_OUT !== 1'b1 && n < hi + 10)
    begin
      @(posedge REF_CLK);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1, what);
    if (n >= hi + 10)
      results();
  endtask : irq_gap

  task done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    chk(32'(INT_THRESHOLD), 32'h08, "reset threshold");
    chk(32'(PARK_MODE_ON), 32'h1, "reset park on");
    chk(32'(PARK_COUNT), 32'h3, "reset park count");
    chk(32'(FRAME_LIST_SIZE), 32'h0, "reset frame size");
    chk(32'({bare_park, bare_cnt, bare_fls}), 32'h0, "bare reset park and size");
    apb(1'b0, CMD_A, 32'h0);
    chk(rd, 32'h00080B00, "reset command");
    chk(bare_rdata, 32'h00080000, "bare reset command");
    apb(1'b0, CAP_A, 32'h0);
    chk(rd, CAP_EXP, "capability");
    chk(bare_rdata, 32'h00000020, "bare capability");
    apb(1'b0, ROUTE_A, 32'h0);
    chk(rd, ROUTE_EXP, "route");
    done("reset");
    // Read-only words ignore writes without an error
    apb(1'b1, CAP_A, 32'hFFFFFFFF);
    chk(32'(er), 32'h0, "cap write err");
    apb(1'b1, ROUTE_A, 32'hFFFFFFFF);
    apb(1'b0, CAP_A, 32'h0);
    chk(rd, CAP_EXP, "cap after write");
    apb(1'b0, ROUTE_A, 32'h0);
    chk(rd, ROUTE_EXP, "route after write");
    done("read_only");
    apb(1'b0, HOLE_A, 32'h0);
    chk({rd[31:1], er}, 32'h00000001, "hole read");
    apb(1'b1, HOLE_A, 32'h00400000);
    chk(32'(er), 32'h1, "hole write err");
    apb(1'b0, CMD_A, 32'h0);
    chk(rd, 32'h00080B00, "hole write ignored");
    done("unmapped");
    apb(1'b1, CMD_A, 32'hFF40F000);
    apb(1'b0, CMD_A, 32'h0);
    chk(rd, 32'h00400000, "reserved zero");
    chk(32'(PARK_MODE_ON), 32'h0, "park off");
    apb(1'b1, CMD_A, 32'h00010B08);
    apb(1'b0, CMD_A, 32'h0);
    chk(rd, 32'h00010B08, "fields set");
    chk(bare_rdata, 32'h00010000, "bare fields fixed");
    chk(32'({bare_park, bare_cnt, bare_fls}), 32'h0, "bare outputs fixed");
    chk(32'(PARK_MODE_ON), 32'h1, "park on");
    chk(32'(FRAME_LIST_SIZE), 32'h2, "frame size");
    done("command");
    foreach (thr[i])
    begin
      apb(1'b1, CMD_A, {8'h00, thr[i], 16'h0B00});
      apb(1'b0, CMD_A, 32'h0);
      chk(rd, {8'h00, thr[i], 16'h0B00}, "threshold read");
      chk(32'(INT_THRESHOLD), 32'(thr[i]), "threshold out");
    end
    done("thresholds");
    apb(1'b1, CMD_A, 32'h00010B00);
    irq_gap(1, 2 * UF + 4, "first irq");
    irq_gap(UF - 2, 2 * UF + 4, "irq gap one");
    // Threshold changed only right after an interrupt, with nothing pending
    apb(1'b1, CMD_A, 32'h00040B00);
    irq_gap(4 * UF - 6, 4 * UF + 4, "irq after change");
    irq_gap(4 * UF - 2, 5 * UF + 4, "irq gap four");
    done("interrupt");
    // Second reset in mid-run must restore the defaults
    apb(1'b1, CMD_A, 32'h00400000);
    @(posedge REF_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, CMD_A, 32'h0);
    chk(rd, 32'h00080B00, "command after reset");
    chk(32'(INT_THRESHOLD), 32'h08, "threshold after reset");
    done("rereset");
    results();
  end
endmodule : usb2_host_capability_command_regs_tb
`default_nettype wire
